// ### dv/timer_pwm_event_flags_tb_top.sv
/*
 * Self-checking bench for the timer/PWM event-flag block.
 * Assumes the zero-wait APB slave and register map of tpe_timer.
 */
`timescale 1ns/1ps
module timer_pwm_event_flags_tb_top;
  localparam logic [7:0] a_sc = tpe_pkg::ADDR_SC;
  localparam logic [7:0] a_ch = tpe_pkg::ADDR_CNT_HI;
  localparam logic [7:0] a_cl = tpe_pkg::ADDR_CNT_LO;
  localparam logic [7:0] a_mh = tpe_pkg::ADDR_MOD_HI;
  localparam logic [7:0] a_ml = tpe_pkg::ADDR_MOD_LO;
  localparam logic [7:0] s0   = 8'(tpe_pkg::CH_BASE);
  localparam logic [7:0] v0h  = s0 + tpe_pkg::OFF_CV_HI;
  localparam logic [7:0] v0l  = s0 + tpe_pkg::OFF_CV_LO;
  localparam logic [7:0] s1   = s0 + 8'(tpe_pkg::CH_STRIDE);
  localparam logic [7:0] v1h  = s1 + tpe_pkg::OFF_CV_HI;
  localparam logic [7:0] v1l  = s1 + tpe_pkg::OFF_CV_LO;
  logic                      clk;
  logic                      sys_rst;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [7:0]                paddr;
  logic [31:0]               pwdata;
  logic                      debug_halt_mode;
  logic [tpe_pkg::NCH-1:0]   ch_pin_in;
  logic                      pready;
  logic [31:0]               prdata;
  logic                      pslverr;
  logic                      irq;
  logic [tpe_pkg::NCH-1:0]   ch_pin_out;
  logic [tpe_pkg::NCH-1:0]   ch_pin_oe;
  logic [7:0]                rdat;
  logic                      rerr;
  logic [7:0]                va;
  logic [7:0]                vb;
  int                        fails;
  int                        checks;

  tpe_timer u_tpe_timer (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .debug_halt_mode(debug_halt_mode), .ch_pin_in(ch_pin_in),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq),
    .ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe));

  // ***************************************************************
  // Tasks
  // ***************************************************************
  // One APB transfer, request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata[7:0];
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(nm, exp, rdat);
  endtask

  task automatic tdone(input string nm);
    $display("test %s done", nm);
  endtask

  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ***************************************************************
  // Clock, watchdog and tests
  // ***************************************************************
  initial clk = 1'b0;
  always #4 clk = ~clk;

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("mismatch watchdog expected done seen hang");
    results();
  end

  // Main sequence
  initial begin
    {psel, penable, pwrite, debug_halt_mode} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    ch_pin_in = '0;
    fails = 0;
    checks = 0;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values and a refused address
    rdc("sc_reset", a_sc, 8'h00);
    rdc("csc0_reset", s0, 8'h00);
    rdc("cnt_reset", a_cl, 8'h00);
    xfer(1'b0, 8'h30, 8'h00);
    chk("bad_addr_err", 8'h01, 8'(rerr));
    chk("bad_addr_data", 8'h00, rdat);
    tdone("reset");
    // Up-count overflow, clear needs a read first
    wr(a_mh, 8'h00);
    wr(a_ml, 8'h40);
    wr(a_cl, 8'h00);
    wr(a_sc, 8'h48);
    repeat (80) @(posedge clk);
    chk("irq_ovf", 8'h01, 8'(irq));
    wr(a_sc, 8'h40);
    rdc("ovf_kept", a_sc, 8'hc0);
    wr(a_sc, 8'h40);
    rdc("ovf_clear", a_sc, 8'h40);
    chk("irq_clear", 8'h00, 8'(irq));
    // Center mode turn
    wr(a_cl, 8'h00);
    wr(a_sc, 8'h28);
    repeat (30) @(posedge clk);
    rdc("ctr_rising", a_sc, 8'h28);
    repeat (60) @(posedge clk);
    wr(a_sc, 8'h20);
    rdc("ctr_turn", a_sc, 8'ha0);
    wr(a_sc, 8'h00);
    tdone("overflow");
    // Output compare, direct and buffered loads
    wr(s0, 8'h14);
    wr(v0h, 8'h00);
    wr(v0l, 8'h20);
    rdc("cv_now", v0l, 8'h20);
    chk("oe0", 8'h01, 8'(ch_pin_oe[0]));
    wr(a_cl, 8'h00);
    wr(a_sc, 8'h08);
    repeat (40) @(posedge clk);
    wr(a_sc, 8'h00);
    rdc("cmp_flag", s0, 8'h94);
    chk("cmp_pin", 8'h01, 8'(ch_pin_out[0]));
    wr(a_sc, 8'h0f);
    wr(a_cl, 8'h00);
    wr(v0h, 8'h00);
    wr(v0l, 8'h30);
    rdc("cv_held", v0l, 8'h20);
    repeat (140) @(posedge clk);
    rdc("cv_loaded", v0l, 8'h30);
    wr(a_sc, 8'h00);
    tdone("compare");
    // Edge PWM, flag at end of duty, value loads at top
    wr(s0, 8'h28);
    wr(v0h, 8'h00);
    wr(v0l, 8'h10);
    wr(a_cl, 8'h00);
    wr(a_sc, 8'h08);
    repeat (8) @(posedge clk);
    chk("pwm_on", 8'h01, 8'(ch_pin_out[0]));
    repeat (20) @(posedge clk);
    chk("pwm_off", 8'h00, 8'(ch_pin_out[0]));
    rdc("pwm_flag", s0, 8'ha8);
    wr(v0h, 8'h00);
    wr(v0l, 8'h20);
    rdc("pwm_held", v0l, 8'h10);
    repeat (40) @(posedge clk);
    rdc("pwm_loaded", v0l, 8'h20);
    wr(a_sc, 8'h00);
    tdone("pwm");
    // Capture edges for every edge select, value writes ignored
    wr(a_cl, 8'h00);
    for (int e = 0; e < 4; e++) begin
      wr(s1, 8'(e << 2));
      ch_pin_in[1] <= 1'b1;
      repeat (8) @(posedge clk);
      rdc("cap_rise", s1, {e[0], 3'h0, 2'(e), 2'h0});
      wr(s1, 8'(e << 2));
      ch_pin_in[1] <= 1'b0;
      repeat (8) @(posedge clk);
      rdc("cap_fall", s1, {e[1], 3'h0, 2'(e), 2'h0});
      wr(s1, 8'(e << 2));
    end
    wr(s1, 8'h00);
    wr(v1h, 8'h12);
    wr(v1l, 8'h34);
    rdc("cap_hi", v1h, 8'h00);
    rdc("cap_lo", v1l, 8'h00);
    tdone("capture");
    // Debug halt reads and counter clear
    wr(a_mh, 8'h00);
    wr(a_ml, 8'h00);
    wr(a_cl, 8'h00);
    wr(a_sc, 8'h08);
    xfer(1'b0, a_cl, 8'h00);
    va = rdat;
    xfer(1'b0, a_ch, 8'h00);
    repeat (30) @(posedge clk);
    debug_halt_mode <= 1'b1;
    xfer(1'b0, a_cl, 8'h00);
    vb = rdat;
    chk("halt_live", 8'h01, 8'(vb - va > 8'd20));
    rdc("halt_frozen", a_cl, vb);
    wr(a_ch, 8'h00);
    rdc("halt_clr_lo", a_cl, 8'h00);
    wr(a_sc, 8'h00);
    debug_halt_mode <= 1'b0;
    rdc("unhalt_lo", a_cl, 8'h00);
    tdone("halt");
    results();
  end
endmodule

bind tpe_timer tpe_timer_properties u_tpe_timer_properties (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .irq(irq));

// ### dv/tpe_timer_properties.sv
/*
 * Concurrent checks on the ports of the timer/PWM event-flag block.
 * Assumes one clock domain, reset asynchronous and active high, and an
 * APB master that inserts no wait of its own between setup and access.
 */
`timescale 1ns/1ps
module tpe_timer_properties (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        irq
);
  localparam logic [7:0] s0 = 8'(tpe_pkg::CH_BASE);
  localparam logic [7:0] s1 = 8'(tpe_pkg::CH_BASE + tpe_pkg::CH_STRIDE);
  localparam logic [7:0] top = s1 + tpe_pkg::OFF_CV_LO;
  logic [2:0] ie_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // ***************************************************************
  // Helper logic
  // ***************************************************************
  // Interrupt enables as last written by software
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ie_q <= 3'h0;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == tpe_pkg::ADDR_SC) ie_q[0] <= pwdata[6];
      if (paddr == s0) ie_q[1] <= pwdata[6];
      if (paddr == s1) ie_q[2] <= pwdata[6];
    end
  end

  // ***************************************************************
  // Properties
  // ***************************************************************
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence

  ready_after_setup_a: assert property (setup_s |=> pready)
    else $error("pready missing after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  bad_addr_err_a: assert property (
    setup_s ##0 (paddr > top && paddr[1:0] == 2'h0) |=> pslverr)
    else $error("unmapped address not refused");
  good_addr_ok_a: assert property (
    setup_s ##0 (paddr <= top && paddr[1:0] == 2'h0) |=> !pslverr)
    else $error("mapped address refused");
  read_high_zero_a: assert property (
    access_s ##0 !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  err_read_zero_a: assert property (
    access_s ##0 (pslverr && !pwrite) |-> prdata == 32'h00000000)
    else $error("refused read returned data");
  prdata_holds_a: assert property (
    $changed(prdata) |-> $past(psel) && !$past(penable))
    else $error("read data changed outside setup");
  irq_needs_enable_a: assert property (irq |-> |ie_q)
    else $error("irq high with all enables off");
endmodule

// ### hdl/tpe_pin_sync.sv
/*
 * Two-flop pin synchroniser with registered rise and fall pulses.
 * Assumes the pin is asynchronous to clk.
 */
`timescale 1ns/1ps
module tpe_pin_sync (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  output logic      rise,
  output logic      fall
);

  tpe_pkg::tpe_sync_t q;
  tpe_pkg::tpe_sync_t d;

  // Shift chain; only s2 and s3 feed the edge detect
  always_comb begin
    d      = q;
    d.s1   = pin_in;
    d.s2   = q.s1;
    d.s3   = q.s2;
    d.rise = q.s2 & ~q.s3;
    d.fall = ~q.s2 & q.s3;
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rise = q.rise;
  assign fall = q.fall;

endmodule

// ### hdl/tpe_pkg.sv
/*
 * Constants and state type for the timer/PWM event-flag block.
 * Assumes a 32-bit APB bus where each byte-wide register takes one word.
 */
package tpe_pkg;

  // ***************************************************************
  // Sizes
  // ***************************************************************
  localparam int NCH = 2;

  // ***************************************************************
  // Register byte addresses
  // ***************************************************************
  localparam logic [7:0] ADDR_SC        = 8'h00;
  localparam logic [7:0] ADDR_CNT_HI    = 8'h04;
  localparam logic [7:0] ADDR_CNT_LO    = 8'h08;
  localparam logic [7:0] ADDR_MOD_HI    = 8'h0c;
  localparam logic [7:0] ADDR_MOD_LO    = 8'h10;
  localparam int         CH_BASE        = 'h14;
  localparam int         CH_STRIDE      = 'h0c;
  localparam logic [7:0] OFF_CSC        = 8'h00;
  localparam logic [7:0] OFF_CV_HI      = 8'h04;
  localparam logic [7:0] OFF_CV_LO      = 8'h08;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int SC_FLAG_BIT  = 7;
  localparam int SC_IE_BIT    = 6;
  localparam int SC_CPWM_BIT  = 5;
  localparam int SC_CLKS_LSB  = 3;
  localparam int SC_PS_LSB    = 0;
  localparam int CSC_FLAG_BIT = 7;
  localparam int CSC_IE_BIT   = 6;
  localparam int CSC_MS_LSB   = 4;
  localparam int CSC_ELS_LSB  = 2;

  // ***************************************************************
  // Counter values, reset values and edge select codes
  // ***************************************************************
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_FREE = 16'hffff;
  localparam logic [7:0]  SC_RST   = 8'h00;
  localparam logic [7:0]  CSC_RST  = 8'h00;
  localparam logic [15:0] MOD_RST  = 16'h0000;
  localparam logic [1:0]  ELS_RISE = 2'h1;
  localparam logic [1:0]  ELS_FALL = 2'h2;
  localparam logic [1:0]  ELS_BOTH = 2'h3;

  // ***************************************************************
  // Whole state of the timer
  // ***************************************************************
  typedef struct packed {
    logic                       overflow_flag;
    logic                       overflow_arm;
    logic                       overflow_irq_enable;
    logic                       center_mode_select;
    logic [1:0]                 clock_source_select;
    logic [2:0]                 prescale;
    logic [6:0]                 pre_cnt;
    logic [15:0]                cnt;
    logic                       down;
    logic [15:0]                modulo_value;
    logic [15:0]                mod_buf;
    logic [1:0]                 mod_wr;
    logic                       cnt_rd_lat;
    logic [7:0]                 cnt_rd_buf;
    logic [NCH-1:0]             channel_event_flag;
    logic [NCH-1:0]             ch_arm;
    logic [NCH-1:0]             channel_irq_enable;
    logic [NCH-1:0][1:0]        ch_mode;
    logic [NCH-1:0][1:0]        ch_els;
    logic [NCH-1:0][15:0]       channel_value;
    logic [NCH-1:0][15:0]       cv_buf;
    logic [NCH-1:0][1:0]        cv_wr;
    logic [NCH-1:0][15:0]       duty;
    logic [NCH-1:0]             cv_rd_lat;
    logic [NCH-1:0][7:0]        cv_rd_buf;
    logic [NCH-1:0]             pin;
    logic [NCH-1:0]             pin_oe;
    logic                       irq;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
  } tpe_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
    logic fall;
  } tpe_sync_t;

endpackage

// ### hdl/tpe_timer.sv
/*
 * 16-bit timer/PWM with overflow and channel event flags, buffered
 * channel and modulo updates, debug-halt coherency, on an APB slave.
 * Assumes debug_halt_mode comes from logic on clk; channel pins are
 * asynchronous and pass through tpe_pin_sync.
 */
`timescale 1ns/1ps
// Behaviour
// - Up counting: overflow flag on modulo-to-zero step, or on FFFF-to-zero step when modulo is zero.
// - Center mode: overflow flag when counter turns from up to down.
// - Capture: edge select picks none, rising, falling, both; sets flag.
// - Output compare: flag on every counter match with channel value.
// - Edge PWM: flag on counter match, end of active duty.
// - Center PWM: flag on both matches per period.
// - Flag clears by read-while-set then write zero; new event wins.
// - Interrupt high while any flag and its enable are both set.
// - Counter byte write clears counter and prescaler.
// - In debug halt, counter reads give the frozen live count.
// - In debug halt, control or counter write clears counter latch.
// - Debug halt: value reads live; control write clears channel latch.
// - Capture mode ignores writes to the channel value.
// - Compare with clock on: buffer loads at next counter increment.
// - PWM with clock on: buffer loads as counter reaches top.
// - No clock source: buffer loads when second byte written.
// - Center PWM with value equal to modulo gives full duty.
// - Center PWM with value modulo minus one gives nearly full duty.
// - Center value from zero to non-zero applies next period.
// - Center value from non-zero to zero finishes current period.
// - Control write in debug halt clears modulo write latch.
module tpe_timer (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic                     debug_halt_mode,
  input  wire logic [tpe_pkg::NCH-1:0]  ch_pin_in,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  output logic                          irq,
  output logic [tpe_pkg::NCH-1:0]       ch_pin_out,
  output logic [tpe_pkg::NCH-1:0]       ch_pin_oe
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  tpe_pkg::tpe_state_t         q;
  tpe_pkg::tpe_state_t         d;
  logic [tpe_pkg::NCH-1:0]     ch_rise;
  logic [tpe_pkg::NCH-1:0]     ch_fall;
  logic                        setup;
  logic                        wr;
  logic                        rd;
  logic                        hit;
  logic [7:0]                  wb;
  logic [7:0]                  rbyte;
  logic                        halt;
  logic                        tick;
  logic [6:0]                  pre_last;
  logic [15:0]                 top;
  logic [15:0]                 nxt;
  logic                        wrap;
  logic                        turn;
  logic                        ev_tof;
  logic [tpe_pkg::NCH-1:0]     ev_ch;
  logic [7:0]                  chb;
  logic                        ic;
  logic                        oc;
  logic                        epwm;
  logic                        active;

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < tpe_pkg::NCH; g++) begin : g_sync
      tpe_pin_sync u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin_in  (ch_pin_in[g]),
        .rise    (ch_rise[g]),
        .fall    (ch_fall[g])
      );
    end
  endgenerate

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    d        = q;
    halt     = debug_halt_mode;
    setup    = psel & ~penable;
    wr       = psel & penable & q.pready & pwrite;
    rd       = setup & ~pwrite;
    wb       = pwdata[7:0];
    hit      = 1'b0;
    rbyte    = 8'h00;
    ev_tof   = 1'b0;
    ev_ch    = '0;
    chb      = 8'h00;
    ic       = 1'b0;
    oc       = 1'b0;
    epwm     = 1'b0;
    active   = 1'b0;
    wrap     = 1'b0;
    turn     = 1'b0;

    // Prescaler and counter step
    pre_last = 7'((8'h01 << q.prescale) - 8'h01);
    tick     = (q.clock_source_select != 2'h0) && !halt
               && (q.pre_cnt == pre_last);
    top      = (q.modulo_value == tpe_pkg::CNT_ZERO) ?
               tpe_pkg::CNT_FREE : q.modulo_value;
    if (q.center_mode_select) begin
      if (!q.down) begin
        turn = (q.cnt >= q.modulo_value);
        nxt  = turn ? q.cnt - 16'h0001 : q.cnt + 16'h0001;
      end else begin
        nxt  = (q.cnt == tpe_pkg::CNT_ZERO) ?
               q.cnt + 16'h0001 : q.cnt - 16'h0001;
      end
    end else begin
      wrap = (q.cnt == top);
      nxt  = wrap ? tpe_pkg::CNT_ZERO : q.cnt + 16'h0001;
    end
    if (tick) begin
      d.pre_cnt = 7'h00;
      d.cnt     = nxt;
      ev_tof    = wrap | turn;
      if (turn) begin
        d.down = 1'b1;
      end else if (q.down && q.cnt == tpe_pkg::CNT_ZERO) begin
        d.down = 1'b0;
      end
    end else if (q.clock_source_select != 2'h0 && !halt) begin
      d.pre_cnt = q.pre_cnt + 7'h01;
    end

    // Buffered modulo load once both bytes are in
    if (q.mod_wr == 2'h3 && (q.clock_source_select == 2'h0
        || (tick && (wrap | turn)))) begin
      d.modulo_value = q.mod_buf;
      d.mod_wr       = 2'h0;
    end

    // Per-channel modes, events, loads and pin drive
    for (int i = 0; i < tpe_pkg::NCH; i++) begin
      ic   = !q.center_mode_select && q.ch_mode[i] == 2'h0;
      oc   = !q.center_mode_select && q.ch_mode[i] == 2'h1;
      epwm = !q.center_mode_select && q.ch_mode[i][1];
      if (ic) begin
        ev_ch[i] = (q.ch_els[i][0] & ch_rise[i])
                 | (q.ch_els[i][1] & ch_fall[i]);
        if (ev_ch[i]) begin
          d.channel_value[i] = q.cnt;
        end
      end else begin
        ev_ch[i] = tick && nxt == q.channel_value[i];
      end
      // Channel value buffer transfer
      if (q.cv_wr[i] == 2'h3 && !ic) begin
        if (q.clock_source_select == 2'h0
            || (oc && tick)
            || (!oc && tick && !q.down && nxt == top)) begin
          d.channel_value[i] = q.cv_buf[i];
          d.cv_wr[i]         = 2'h0;
        end
      end
      // Center duty is taken only at the period boundary
      if (tick && turn) begin
        d.duty[i] = q.channel_value[i];
      end
      if (oc) begin
        if (ev_ch[i]) begin
          case (q.ch_els[i])
            tpe_pkg::ELS_RISE: d.pin[i] = ~q.pin[i];
            tpe_pkg::ELS_FALL: d.pin[i] = 1'b0;
            tpe_pkg::ELS_BOTH: d.pin[i] = 1'b1;
            default:           d.pin[i] = q.pin[i];
          endcase
        end
      end else if (epwm) begin
        active   = q.cnt < q.channel_value[i];
        d.pin[i] = active ^ q.ch_els[i][0];
      end else if (q.center_mode_select) begin
        active   = (q.duty[i] != tpe_pkg::CNT_ZERO) && !q.duty[i][15]
                 && ((q.duty[i] >= q.modulo_value)
                     || (q.cnt < q.duty[i]));
        d.pin[i] = active ^ q.ch_els[i][0];
      end
      d.pin_oe[i] = (q.ch_els[i] != 2'h0) && !ic;
    end

    // APB handshake, one access cycle per transfer
    d.pready = setup;

    // Timer control and counter
    if (paddr == tpe_pkg::ADDR_SC) begin
      hit   = 1'b1;
      rbyte = {q.overflow_flag, q.overflow_irq_enable,
               q.center_mode_select, q.clock_source_select, q.prescale};
      if (rd && q.overflow_flag) begin
        d.overflow_arm = 1'b1;
      end
      if (wr) begin
        d.overflow_irq_enable = wb[tpe_pkg::SC_IE_BIT];
        d.center_mode_select  = wb[tpe_pkg::SC_CPWM_BIT];
        d.clock_source_select = wb[tpe_pkg::SC_CLKS_LSB +: 2];
        d.prescale            = wb[tpe_pkg::SC_PS_LSB +: 3];
        d.mod_wr              = 2'h0;
        if (!wb[tpe_pkg::SC_FLAG_BIT] && q.overflow_arm) begin
          d.overflow_flag = 1'b0;
          d.overflow_arm  = 1'b0;
        end
        if (halt) begin
          d.cnt_rd_lat = 1'b0;
        end
      end
    end
    if (paddr == tpe_pkg::ADDR_CNT_HI || paddr == tpe_pkg::ADDR_CNT_LO) begin
      hit = 1'b1;
      if (paddr == tpe_pkg::ADDR_CNT_HI) begin
        rbyte = q.cnt[15:8];
        if (rd && !halt) begin
          d.cnt_rd_buf = q.cnt[7:0];
          d.cnt_rd_lat = 1'b1;
        end
      end else begin
        rbyte = (q.cnt_rd_lat && !halt) ? q.cnt_rd_buf : q.cnt[7:0];
        if (rd && !halt) begin
          d.cnt_rd_lat = 1'b0;
        end
      end
      if (wr) begin
        d.cnt     = tpe_pkg::CNT_ZERO;
        d.pre_cnt = 7'h00;
        d.down    = 1'b0;
        if (halt) begin
          d.cnt_rd_lat = 1'b0;
        end
      end
    end
    if (paddr == tpe_pkg::ADDR_MOD_HI) begin
      hit   = 1'b1;
      rbyte = q.modulo_value[15:8];
      if (wr) begin
        d.mod_buf[15:8] = wb;
        d.mod_wr[1]     = 1'b1;
      end
    end
    if (paddr == tpe_pkg::ADDR_MOD_LO) begin
      hit   = 1'b1;
      rbyte = q.modulo_value[7:0];
      if (wr) begin
        d.mod_buf[7:0] = wb;
        d.mod_wr[0]    = 1'b1;
      end
    end

    // Channel registers
    for (int i = 0; i < tpe_pkg::NCH; i++) begin
      chb = 8'(tpe_pkg::CH_BASE + i * tpe_pkg::CH_STRIDE);
      ic  = !q.center_mode_select && q.ch_mode[i] == 2'h0;
      if (paddr == chb + tpe_pkg::OFF_CSC) begin
        hit   = 1'b1;
        rbyte = {q.channel_event_flag[i], q.channel_irq_enable[i],
                 q.ch_mode[i], q.ch_els[i], 2'h0};
        if (rd && q.channel_event_flag[i]) begin
          d.ch_arm[i] = 1'b1;
        end
        if (wr) begin
          d.channel_irq_enable[i] = wb[tpe_pkg::CSC_IE_BIT];
          d.ch_mode[i]            = wb[tpe_pkg::CSC_MS_LSB +: 2];
          d.ch_els[i]             = wb[tpe_pkg::CSC_ELS_LSB +: 2];
          d.cv_wr[i]              = 2'h0;
          if (!wb[tpe_pkg::CSC_FLAG_BIT] && q.ch_arm[i]) begin
            d.channel_event_flag[i] = 1'b0;
            d.ch_arm[i]             = 1'b0;
          end
          if (halt) begin
            d.cv_rd_lat[i] = 1'b0;
          end
        end
      end
      if (paddr == chb + tpe_pkg::OFF_CV_HI) begin
        hit   = 1'b1;
        rbyte = q.channel_value[i][15:8];
        if (rd && !halt) begin
          d.cv_rd_buf[i] = q.channel_value[i][7:0];
          d.cv_rd_lat[i] = 1'b1;
        end
        if (wr && !ic) begin
          d.cv_buf[i][15:8] = wb;
          d.cv_wr[i][1]     = 1'b1;
        end
      end
      if (paddr == chb + tpe_pkg::OFF_CV_LO) begin
        hit   = 1'b1;
        rbyte = (q.cv_rd_lat[i] && !halt) ? q.cv_rd_buf[i]
                                          : q.channel_value[i][7:0];
        if (rd && !halt) begin
          d.cv_rd_lat[i] = 1'b0;
        end
        if (wr && !ic) begin
          d.cv_buf[i][7:0] = wb;
          d.cv_wr[i][0]    = 1'b1;
        end
      end
    end
    // Error flag stands only in the access cycle
    d.pslverr = setup & ~hit;
    if (setup) begin
      d.prdata  = {24'h000000, rbyte};
    end

    // Events win over a clear in the same cycle
    if (ev_tof) begin
      d.overflow_flag = 1'b1;
      d.overflow_arm  = 1'b0;
    end
    for (int i = 0; i < tpe_pkg::NCH; i++) begin
      if (ev_ch[i]) begin
        d.channel_event_flag[i] = 1'b1;
        d.ch_arm[i]             = 1'b0;
      end
    end
    d.irq = (d.overflow_flag & d.overflow_irq_enable)
          | |(d.channel_event_flag & d.channel_irq_enable);
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign pready     = q.pready;
  assign prdata     = q.prdata;
  assign pslverr    = q.pslverr;
  assign irq        = q.irq;
  assign ch_pin_out = q.pin;
  assign ch_pin_oe  = q.pin_oe;

endmodule
